//--- hdl/cwf_consts.vh
// Constants of the continuous weight frame transmitter.
// Assumes a 250 MHz reference clock; included by bare name.
`ifndef CWF_CONSTS_VH
`define CWF_CONSTS_VH

// ==================================================
// Frame and flow control characters
`define CWF_CHR_STX 8'h02
`define CWF_CHR_CR 8'h0d
`define CWF_CHR_SPACE 8'h20
`define CWF_CHR_ZERO 8'h30
`define CWF_CHR_XON 8'h11
`define CWF_CHR_XOFF 8'h13

// ==================================================
// Byte positions, counted from zero
`define CWF_POS_STX 5'h00
`define CWF_POS_FSB 5'h01
`define CWF_POS_SSB 5'h02
`define CWF_POS_TSB 5'h03
`define CWF_POS_WT0 5'h04
`define CWF_POS_WT5 5'h09
`define CWF_POS_TR0 5'h0a
`define CWF_POS_TR5 5'h0f
`define CWF_POS_CR 5'h10
`define CWF_POS_CHK 5'h11

// ==================================================
// Parity selections
`define CWF_PAR_NONE 2'h0
`define CWF_PAR_EVEN 2'h1
`define CWF_PAR_ODD 2'h2

// ==================================================
// Timing
`define CWF_CLK_KHZ 250000
`define CWF_TICK_MS 1
`define CWF_DEF_PERIOD_MS 8'h32
// Reference clock cycles in one millisecond
`define CWF_MS_CYCLES 18'h3d090

// ==================================================
// Baud divisors at 250 MHz, 300 up to 115200 baud
`define CWF_DIV_300 20'hcb735
`define CWF_DIV_600 20'h65b9b
`define CWF_DIV_1200 20'h32dcd
`define CWF_DIV_2400 20'h196e7
`define CWF_DIV_4800 20'h0cb73
`define CWF_DIV_9600 20'h065ba
`define CWF_DIV_19200 20'h032dd
`define CWF_DIV_38400 20'h0196e
`define CWF_DIV_57600 20'h010f4
`define CWF_DIV_115200 20'h0087a

`endif

//--- hdl/cwf_fifo.v
// Byte FIFO between the frame builder and the output stage.
// Assumes one clock; read data is valid while out_valid is high.
`timescale 1ns/1ns
`default_nettype none

module cwf_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  wire do_wr;
  wire do_rd;
  wire full;
  wire empty;

  // ==================================================
  // Flags
  // Extra pointer bit tells full from empty
  assign empty = (wr_q == rd_q);
  assign full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign do_wr = in_valid && !full;
  assign do_rd = out_ready && !empty;
  assign out_data = mem_q[rd_q[AW-1:0]];

  // ==================================================
  // Storage
  always @(posedge ref_clk) begin
    if (do_wr) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  // ==================================================
  // Pointers
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_rd) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

//--- hdl/cwf_frame_tx.v
// Continuous weight frame transmitter.
// Assumes a UART bit engine that takes tx_byte on tx_valid and
// tx_ready, and hands received characters on rx_valid.
`timescale 1ns/1ns
`default_nettype none
`include "cwf_consts.vh"

module cwf_frame_tx #(
  parameter [17:0] MS_CYCLES = `CWF_MS_CYCLES
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Weight and tare, six BCD digits each, leading digit on top
  input wire [23:0] wt_digits,
  input wire [23:0] tare_digits,
  // Scale status
  input wire [2:0] dec_code,
  input wire [1:0] incr_code,
  input wire is_net,
  input wire is_negative,
  input wire out_of_range,
  input wire in_motion,
  input wire unit_kg,
  input wire zero_not_captured,
  input wire [2:0] unit_code,
  input wire print_pending,
  input wire expand_x10,
  // Configuration
  input wire cont_enable,
  input wire chk_enable,
  input wire [1:0] parity_sel,
  input wire [3:0] baud_sel,
  input wire [7:0] output_rate_setting,
  input wire [6:0] port_assign,
  // Received characters, for flow control
  input wire rx_valid,
  input wire [7:0] rx_byte,
  // Transmit character stream
  input wire tx_ready,
  output reg tx_valid,
  output reg [7:0] tx_byte,
  // Line format to the bit engine
  output reg [19:0] baud_div,
  output reg [1:0] parity_mode,
  output reg [6:0] port_enable,
  // Status
  output reg xoff_active,
  output reg frame_active
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SEND = 2'h1;
  localparam [1:0] ST_DRAIN = 2'h2;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [4:0] idx_q;
  reg [4:0] idx_d;
  reg [7:0] fsb_q;
  reg [7:0] ssb_q;
  reg [7:0] tsb_q;
  reg [23:0] wt_q;
  reg [23:0] tr_q;
  reg chk_q;
  reg [1:0] par_q;
  reg blank_q;
  reg [6:0] sum_q;
  reg [17:0] tick_q;
  reg [7:0] ms_q;
  reg [7:0] cur_byte;
  reg [3:0] cur_dig;
  reg [7:0] period_ms;
  reg [19:0] div_d;
  wire [7:0] fsb_d;
  wire [7:0] ssb_d;
  wire [7:0] tsb_d;
  wire [4:0] last_idx;
  wire is_digit;
  wire is_wt;
  wire group_end;
  wire [6:0] chk_low;
  wire due;
  wire start;
  wire push;
  wire f_in_ready;
  wire f_out_valid;
  wire [7:0] f_out_data;
  wire f_pop;

  // ==================================================
  // Status bytes
  assign fsb_d = {1'b0, 1'b1,
                  incr_code,
                  dec_code};
  assign ssb_d = {zero_not_captured,
                  1'b1,
                  unit_kg,
                  in_motion, out_of_range,
                  is_negative, is_net};
  assign tsb_d = {1'b0, 1'b1,
                  expand_x10, print_pending,
                  unit_code};

  // ==================================================
  // Frame pacing
  // Zero in the rate setting keeps the default period
  always @* begin
    if (output_rate_setting == 8'h00) begin
      period_ms = `CWF_DEF_PERIOD_MS;
    end else begin
      period_ms = output_rate_setting;
    end
  end

  // A slow line is still draining when the period ends, so
  // the next frame simply follows the last byte out.
  assign due = (ms_q >= period_ms);
  assign start = (state_q == ST_IDLE) && cont_enable && due;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_q <= 18'h00000;
      ms_q <= 8'h00;
    end else if (start) begin
      tick_q <= 18'h00000;
      ms_q <= 8'h00;
    end else if (tick_q == MS_CYCLES - 18'h00001) begin
      tick_q <= 18'h00000;
      if (!due) begin
        ms_q <= ms_q + 8'h01;
      end
    end else begin
      tick_q <= tick_q + 18'h00001;
    end
  end

  // ==================================================
  // Byte generation
  assign last_idx = chk_q ? `CWF_POS_CHK : `CWF_POS_CR;
  assign is_wt = (idx_q >= `CWF_POS_WT0) && (idx_q <= `CWF_POS_WT5);
  assign is_digit = (idx_q >= `CWF_POS_WT0) && (idx_q <= `CWF_POS_TR5);
  assign group_end = (idx_q == `CWF_POS_WT5) || (idx_q == `CWF_POS_TR5);
  assign chk_low = 7'h00 - sum_q;

  always @* begin
    case (idx_q)
      `CWF_POS_WT0, `CWF_POS_TR0: cur_dig = is_wt ? wt_q[23:20] : tr_q[23:20];
      5'h05, 5'h0b: cur_dig = is_wt ? wt_q[19:16] : tr_q[19:16];
      5'h06, 5'h0c: cur_dig = is_wt ? wt_q[15:12] : tr_q[15:12];
      5'h07, 5'h0d: cur_dig = is_wt ? wt_q[11:8] : tr_q[11:8];
      5'h08, 5'h0e: cur_dig = is_wt ? wt_q[7:4] : tr_q[7:4];
      `CWF_POS_WT5, `CWF_POS_TR5: cur_dig = is_wt ? wt_q[3:0] : tr_q[3:0];
      default: cur_dig = 4'h0;
    endcase
  end

  // Fixed order, nothing but the checksum is optional
  always @* begin
    case (idx_q)
      `CWF_POS_STX: cur_byte = `CWF_CHR_STX;
      `CWF_POS_FSB: cur_byte = fsb_q;
      `CWF_POS_SSB: cur_byte = ssb_q;
      `CWF_POS_TSB: cur_byte = tsb_q;
      `CWF_POS_CR: cur_byte = `CWF_CHR_CR;
      `CWF_POS_CHK: begin
        case (par_q)
          `CWF_PAR_EVEN: cur_byte = {^chk_low, chk_low};
          `CWF_PAR_ODD: cur_byte = {~^chk_low, chk_low};
          default: cur_byte = {1'b0, chk_low};
        endcase
      end
      default: begin
        // Last digit of a group always shows, even when zero
        if (blank_q && cur_dig == 4'h0 && !group_end) begin
          cur_byte = `CWF_CHR_SPACE;
        end else begin
          cur_byte = `CWF_CHR_ZERO | {4'h0, cur_dig};
        end
      end
    endcase
  end

  // ==================================================
  // Frame sequencer
  assign push = (state_q == ST_SEND) && f_in_ready;

  always @* begin
    state_d = state_q;
    idx_d = idx_q;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d = ST_SEND;
          idx_d = `CWF_POS_STX;
        end
      end
      ST_SEND: begin
        if (push) begin
          if (idx_q == last_idx) begin
            state_d = ST_DRAIN;
          end else begin
            idx_d = idx_q + 5'h01;
          end
        end
      end
      ST_DRAIN: begin
        // Wait until the whole frame has left the block
        if (!f_out_valid && !tx_valid) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Inputs are caught at frame start so a frame never mixes
  // two weighings.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      idx_q <= 5'h00;
      fsb_q <= 8'h00;
      ssb_q <= 8'h00;
      tsb_q <= 8'h00;
      wt_q <= 24'h000000;
      tr_q <= 24'h000000;
      chk_q <= 1'b0;
      par_q <= 2'h0;
      blank_q <= 1'b1;
      sum_q <= 7'h00;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      if (start) begin
        fsb_q <= fsb_d;
        ssb_q <= ssb_d;
        tsb_q <= tsb_d;
        wt_q <= wt_digits;
        tr_q <= tare_digits;
        chk_q <= chk_enable;
        par_q <= parity_sel;
        sum_q <= 7'h00;
        blank_q <= 1'b1;
      end else if (push) begin
        sum_q <= sum_q + cur_byte[6:0];
        if (group_end) begin
          blank_q <= 1'b1;
        end else if (is_digit && cur_dig != 4'h0) begin
          blank_q <= 1'b0;
        end
      end
    end
  end

  // ==================================================
  // Byte buffer
  cwf_fifo #(
    .WIDTH(8),
    .DEPTH(16),
    .AW(4)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .in_valid(state_q == ST_SEND),
    .in_ready(f_in_ready),
    .in_data(cur_byte),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_out_data)
  );

  // ==================================================
  // Flow control and output stage
  // A byte already offered when XOFF lands may still go out;
  // the engine has usually started it anyway.
  assign f_pop = f_out_valid && !xoff_active
                 && (!tx_valid || tx_ready);

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      xoff_active <= 1'b0;
      tx_valid <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      if (rx_valid && rx_byte == `CWF_CHR_XOFF) begin
        xoff_active <= 1'b1;
      end else if (rx_valid && rx_byte == `CWF_CHR_XON) begin
        xoff_active <= 1'b0;
      end
      if (f_pop) begin
        tx_valid <= 1'b1;
        tx_byte <= f_out_data;
      end else if (tx_ready) begin
        tx_valid <= 1'b0;
      end
    end
  end

  // ==================================================
  // Line format
  always @* begin
    case (baud_sel)
      4'h0: div_d = `CWF_DIV_300;
      4'h1: div_d = `CWF_DIV_600;
      4'h2: div_d = `CWF_DIV_1200;
      4'h3: div_d = `CWF_DIV_2400;
      4'h4: div_d = `CWF_DIV_4800;
      4'h5: div_d = `CWF_DIV_9600;
      4'h6: div_d = `CWF_DIV_19200;
      4'h7: div_d = `CWF_DIV_38400;
      4'h8: div_d = `CWF_DIV_57600;
      default: div_d = `CWF_DIV_115200;
    endcase
  end

  // Stop bits are always one, so only parity is passed on
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      baud_div <= `CWF_DIV_9600;
      parity_mode <= `CWF_PAR_NONE;
      port_enable <= 7'h00;
      frame_active <= 1'b0;
    end else begin
      baud_div <= div_d;
      if (parity_sel == `CWF_PAR_EVEN || parity_sel == `CWF_PAR_ODD) begin
        parity_mode <= parity_sel;
      end else begin
        parity_mode <= `CWF_PAR_NONE;
      end
      port_enable <= cont_enable ? port_assign : 7'h00;
      frame_active <= (state_d != ST_IDLE);
    end
  end

endmodule

`default_nettype wire

//--- sim/cwf_frame_tx_monitor.sv
// Port checker for the frame transmitter, bound at its foot.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module cwf_frame_tx_monitor #(
  parameter [17:0] MS_CYCLES = 18'h0000a
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic cont_enable,
  input wire logic [6:0] port_assign,
  input wire logic [6:0] port_enable,
  input wire logic [1:0] parity_sel,
  input wire logic [1:0] parity_mode,
  input wire logic xoff_active,
  input wire logic frame_active
);
  logic [4:0] pos_q;
  logic [4:0] pos_d;
  // ====================
  // Bytes taken in the current frame
  assign pos_d = !frame_active ? 5'h00 :
    pos_q + {4'h0, tx_valid && tx_ready};
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) pos_q <= 5'h00;
    else pos_q <= pos_d;
  end
  // ====================
  // Properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence frame_start;
    $rose(frame_active);
  endsequence
  sequence stx_out;
    tx_valid && tx_byte == 8'h02 && pos_q == 5'h00;
  endsequence
  stx_first_a: assert property (frame_start |-> ##[1:4] stx_out)
    else $error("frame opened without start byte");
  byte_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_byte)) else $error("byte dropped");
  xoff_set_a: assert property (rx_valid && rx_byte == 8'h13
    |=> xoff_active) else $error("pause ignored");
  xon_clr_a: assert property (rx_valid && rx_byte == 8'h11
    |=> !xoff_active) else $error("resume ignored");
  pause_quiet_a: assert property (xoff_active && !tx_valid &&
    !rx_valid |=> !tx_valid) else $error("byte sent while paused");
  port_map_a: assert property (1'b1 |=> port_enable ==
    ($past(cont_enable) ? $past(port_assign) : 7'h00))
    else $error("port enable wrong");
  parity_map_a: assert property (1'b1 |=> parity_mode ==
    ($past(parity_sel) == 2'h3 ? 2'h0 : $past(parity_sel)))
    else $error("parity mode wrong");
  status_bits_a: assert property (tx_valid && pos_q >= 5'h01 &&
    pos_q <= 5'h03 |-> tx_byte[5] && !tx_byte[7])
    else $error("status bit 5 or 7 wrong");
  cr_place_a: assert property (tx_valid && pos_q == 5'h10
    |-> tx_byte == 8'h0d) else $error("byte 17 not CR");
  frame_len_a: assert property ($fell(frame_active)
    |-> pos_q == 5'h11 || pos_q == 5'h12) else $error("frame length");
endmodule
bind cwf_frame_tx cwf_frame_tx_monitor #(.MS_CYCLES(MS_CYCLES)) i_mon (.*);
`default_nettype wire

//--- sim/cwf_remote.sv
// Remote receiver model: collects frame bytes, sends flow characters.
// Assumes it shares the transmitter's clock.
`timescale 1ns/1ns
`default_nettype none
module cwf_remote (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Character stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready,
  // Flow characters
  output logic rx_valid,
  output logic [7:0] rx_byte,
  // Stall control
  input wire logic slow
);
  logic [7:0] got [0:255];
  logic [7:0] pend = 8'h00;
  int req = 0;
  int ack = 0;
  int n = 0;
  // ====================
  // Receive and flow
  always @(posedge ref_clk) begin
    if (tx_valid && tx_ready) begin
      got[n[7:0]] <= tx_byte;
      n <= n + 1;
    end
    // Slow mode halves acceptance so bytes must stand
    tx_ready <= reset_n && (!slow || !tx_ready);
    rx_valid <= reset_n && (req != ack);
    // Idle line never repeats the last character
    rx_byte <= (req != ack) ? pend : ~pend;
    if (req != ack) begin
      ack <= ack + 1;
    end
  end
  // Sends one flow character c as the bench asks, XOFF to pause or XON to resume
  // Request lands by NBA, so the pulse follows on the next edge
  task flow(input logic [7:0] c);
    pend <= c;
    req <= req + 1;
    repeat (3) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the continuous weight frame transmitter.
// Assumes the remote model and the checker are compiled with it.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [23:0] wt_digits = 24'h001230;
  logic [23:0] tare_digits = 24'h000000;
  logic [2:0] dec_code = 3'h4;
  logic [1:0] incr_code = 2'h2;
  logic is_net = 1'b1;
  logic is_negative = 1'b0;
  logic out_of_range = 1'b1;
  logic in_motion = 1'b0;
  logic unit_kg = 1'b1;
  logic zero_not_captured = 1'b1;
  logic [2:0] unit_code = 3'h3;
  logic print_pending = 1'b1;
  logic expand_x10 = 1'b0;
  logic cont_enable = 1'b0;
  logic chk_enable = 1'b0;
  logic [1:0] parity_sel = 2'h0;
  logic [3:0] baud_sel = 4'h0;
  logic [7:0] output_rate_setting = 8'h05;
  logic [6:0] port_assign = 7'h55;
  logic slow = 1'b0;
  logic rx_valid, tx_ready, tx_valid, xoff_active, frame_active;
  logic [7:0] rx_byte, tx_byte;
  logic [19:0] baud_div;
  logic [1:0] parity_mode;
  logic [6:0] port_enable;
  logic [7:0] ex [0:17];
  logic [27:0] rows [0:10];
  int fails = 0;
  int num_checks = 0;
  int cnt, b;
  // ====================
  // Clock, parts and tasks
  always #2 ref_clk = ~ref_clk;
  cwf_frame_tx #(.MS_CYCLES(18'h0000a)) i_dut (.*);
  cwf_remote i_rem (.*);
  task chk(input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wt(input logic v);
    for (int k = 0; k < 5000 && frame_active !== v; k++) begin
      @(posedge ref_clk);
      cnt++;
    end
  endtask
  task mk;
    logic [6:0] s;
    logic [3:0] v;
    logic bl;
    ex[0] = 8'h02;
    ex[1] = {3'h1, incr_code, dec_code};
    ex[2] = {1'b0, zero_not_captured, 1'b1, unit_kg, in_motion,
      out_of_range, is_negative, is_net};
    ex[3] = {3'h1, expand_x10, print_pending, unit_code};
    for (int g = 0; g < 2; g++) begin
      bl = 1'b1;
      for (int d = 0; d < 6; d++) begin
        v = g ? tare_digits[23-4*d -: 4] : wt_digits[23-4*d -: 4];
        bl = bl && v == 4'h0 && d < 5;
        ex[4+6*g+d] = bl ? 8'h20 : {4'h3, v};
      end
    end
    ex[16] = 8'h0d;
    s = 7'h00;
    for (int i = 0; i < 17; i++) s = s + ex[i][6:0];
    s = 7'h00 - s;
    ex[17] = {parity_sel == 2'h1 ? ^s : parity_sel == 2'h2 ? ~^s : 1'b0, s};
  endtask
  task frm(input int len);
    wt(1'b1);
    b = i_rem.n;
    wt(1'b0);
    mk();
    chk(i_rem.n - b, len);
    for (int i = 0; i < len; i++) begin
      chk(32'(i_rem.got[8'(b+i)]), 32'(ex[i]));
    end
  endtask
  task gap(input logic [7:0] r, input int c);
    output_rate_setting <= r;
    wt(1'b1);
    wt(1'b0);
    wt(1'b1);
    cnt = 0;
    wt(1'b0);
    wt(1'b1);
    chk(32'(cnt >= c && cnt <= c + 12), 32'h1);
  endtask
  // ====================
  // Watchdog, well past the expected few thousand cycles
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
  // ====================
  // Main sequence
  initial begin
    rows = '{{4'h0, 2'h1, 20'hcb735, 2'h1}, {4'h1, 2'h2, 20'h65b9b, 2'h2},
      {4'h2, 2'h3, 20'h32dcd, 2'h0}, {4'h3, 2'h0, 20'h196e7, 2'h0},
      {4'h4, 2'h1, 20'h0cb73, 2'h1}, {4'h5, 2'h2, 20'h065ba, 2'h2},
      {4'h6, 2'h3, 20'h032dd, 2'h0}, {4'h7, 2'h0, 20'h0196e, 2'h0},
      {4'h8, 2'h1, 20'h010f4, 2'h1}, {4'h9, 2'h2, 20'h0087a, 2'h2},
      {4'hf, 2'h3, 20'h0087a, 2'h0}};
    repeat (4) @(posedge ref_clk);
    chk(32'(baud_div), 32'h065ba);
    chk(32'({tx_valid, xoff_active}), 32'h0);
    chk(32'({frame_active, port_enable}), 32'h0);
    reset_n <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      @(posedge ref_clk);
      baud_sel <= rows[i][27:24];
      parity_sel <= rows[i][23:22];
      @(posedge ref_clk);
      #1;
      chk(32'(baud_div), 32'(rows[i][21:2]));
      chk(32'(parity_mode), 32'(rows[i][1:0]));
      chk(32'(port_enable), 32'h0);
    end
    @(posedge ref_clk);
    parity_sel <= 2'h0;
    cont_enable <= 1'b1;
    frm(17);
    chk(32'(port_enable), 32'h55);
    chk_enable <= 1'b1;
    parity_sel <= 2'h1;
    slow <= 1'b1;
    tare_digits <= 24'h100005;
    {is_net, is_negative, in_motion, unit_kg} <= 4'h6;
    {dec_code, incr_code, unit_code, expand_x10} <= 9'h0f5;
    frm(18);
    parity_sel <= 2'h2;
    slow <= 1'b0;
    frm(18);
    wt(1'b1);
    repeat (6) @(posedge ref_clk);
    i_rem.flow(8'h13);
    b = i_rem.n;
    repeat (30) @(posedge ref_clk);
    chk(32'(i_rem.n - b <= 1), 32'h1);
    chk(32'(xoff_active), 32'h1);
    i_rem.flow(8'h11);
    wt(1'b0);
    chk(32'(xoff_active), 32'h0);
    gap(8'h0a, 100);
    gap(8'h00, 500);
    cont_enable <= 1'b0;
    wt(1'b0);
    repeat (600) @(posedge ref_clk);
    chk(32'({frame_active, port_enable}), 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
